// file: common/alarm_router_pkg.sv
package alarm_router_pkg;

  // ============================================================
  // Sizes
  localparam int NUM_EVENTS    = 64;
  localparam int EVT_W         = 6;
  localparam int NUM_ACTIONS   = 8;
  localparam int ACT_W         = 3;
  localparam int ROUTE_REGS    = 8;
  localparam int FIELD_STRIDE  = 4;
  localparam int REG_W         = 32;
  localparam int MAX_COUNTERS  = 8;
  localparam int CNT_SEL_W     = 3;
  localparam int ZC_W          = 10;
  localparam int TIMER_W       = 32;
  localparam int SYNC_STAGES   = 3;

  // ============================================================
  // Event allocation
  localparam int WDOG_EVENT    = 1;
  localparam int WDOG_FIRST_ACT = 2;

  // ============================================================
  // Event counter configuration word
  localparam int CNT_EVT_LSB   = 0;
  localparam int CNT_VAL_LSB   = 8;
  localparam int CNT_VAL_W     = 8;
  localparam int CNT_EN_BIT    = 31;

  // ============================================================
  // Watchdog initial value word
  localparam int WDOG_CNT_W    = 24;
  localparam int WDOG_MASK_LSB = 24;
  localparam int WDOG_MASK_W   = 6;
  localparam logic [WDOG_MASK_W-1:0] WDOG_MASK_RST = 6'h3F;
  localparam logic [WDOG_CNT_W-1:0]  WDOG_CNT_RST  = 24'h00_FFFF;

  // ============================================================
  // Reset values
  localparam logic [REG_W-1:0]   REG_ZERO   = 32'h0000_0000;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 32'h0000_0000;
  localparam logic [TIMER_W-1:0] TIMER_ONE  = 32'h0000_0001;

  typedef enum logic [1:0] {
    WD_IDLE,
    WD_COUNT,
    WD_EXPIRED
  } wdog_state_t;

endpackage : alarm_router_pkg

// file: hw/event_sync_edge.sv
`timescale 1ns/1ps
module event_sync_edge #(
  parameter int WIDTH = 64
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Asynchronous event levels
  input  wire logic [WIDTH-1:0] async_in,
  // One-cycle rising-edge pulses
  output logic      [WIDTH-1:0] pulse
);

  logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, pulse_ff;
  logic [WIDTH-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_lvl, nxt_pulse;

  // ============================================================
  // Per-bit synchroniser, filter and edge detector
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        nxt_s1[i] = async_in[i];
        nxt_s2[i] = s1_ff[i];
        nxt_s3[i] = s2_ff[i];
        // Level only moves once two late stages agree
        nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
        // Held levels give one pulse, not one per cycle
        nxt_pulse[i] = nxt_lvl[i] & ~lvl_ff[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      lvl_ff   <= '0;
      pulse_ff <= '0;
    end else begin
      s1_ff    <= nxt_s1;
      s2_ff    <= nxt_s2;
      s3_ff    <= nxt_s3;
      lvl_ff   <= nxt_lvl;
      pulse_ff <= nxt_pulse;
    end
  end

  assign pulse = pulse_ff;

endmodule : event_sync_edge

// file: hw/alarm_watchdog.sv
`timescale 1ns/1ps
module alarm_watchdog
  import alarm_router_pkg::*;
#(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   cold_clr,
  // Trigger sources
  input  wire logic [NUM_ACTIONS-1:0] action,
  input  wire logic [WDOG_MASK_W-1:0] mask,
  input  wire logic [CNT_W-1:0]       init_value,
  // Expiry
  output logic                        irq
);

  wdog_state_t      state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic             irq_ff, nxt_irq;
  logic             trig;

  // ============================================================
  // Countdown
  always_comb begin
    trig      = |(action[NUM_ACTIONS-1:WDOG_FIRST_ACT] & mask);
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_irq   = irq_ff;
    case (state_ff)
      WD_IDLE: begin
        nxt_irq = 1'b0;
        if (trig) begin
          nxt_state = WD_COUNT;
          nxt_cnt   = init_value;
        end
      end
      WD_COUNT: begin
        if (!trig) begin
          nxt_state = WD_IDLE;
          nxt_cnt   = init_value;
        end else if (cnt_ff == '0) begin
          nxt_state = WD_EXPIRED;
          nxt_irq   = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      WD_EXPIRED: begin
        if (!trig) begin
          nxt_state = WD_IDLE;
          nxt_irq   = 1'b0;
          nxt_cnt   = init_value;
        end
      end
      default: begin
        nxt_state = WD_IDLE;
        nxt_irq   = 1'b0;
      end
    endcase
    if (cold_clr) begin
      nxt_state = WD_IDLE;
      nxt_irq   = 1'b0;
      nxt_cnt   = init_value;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= WD_IDLE;
      cnt_ff   <= '0;
      irq_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      irq_ff   <= nxt_irq;
    end
  end

  assign irq = irq_ff;

endmodule : alarm_watchdog

// file: hw/security_event_alarm_router.sv
`timescale 1ns/1ps
module security_event_alarm_router
  import alarm_router_pkg::*;
#(
  parameter int                              NUM_COUNTERS = 4,
  parameter logic [alarm_router_pkg::WDOG_CNT_W-1:0] WDOG_INIT_RESET =
    alarm_router_pkg::WDOG_CNT_RST
) (
  // Clock and power-on reset
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  // Cold reset response, synchronous, active low
  input  wire logic                                   always_on_cold_reset_n,
  // Sensor events
  input  wire logic [alarm_router_pkg::NUM_EVENTS-1:0] event_in,
  // Syndrome clear
  input  wire logic                                   event_clear_wr,
  input  wire logic [alarm_router_pkg::REG_W-1:0]     event_clear_low,
  input  wire logic [alarm_router_pkg::REG_W-1:0]     event_clear_high,
  // Routing select write
  input  wire logic                                   route_wr,
  input  wire logic [alarm_router_pkg::CNT_SEL_W-1:0] route_sel,
  input  wire logic [alarm_router_pkg::REG_W-1:0]     route_wdata,
  // Watchdog initial value
  input  wire logic                                   wdog_iv_wr,
  input  wire logic [alarm_router_pkg::REG_W-1:0]     wdog_iv_wdata,
  output logic      [alarm_router_pkg::REG_W-1:0]     watchdog_initial_value,
  // Event counter configuration
  input  wire logic                                   counter_cfg_wr,
  input  wire logic [alarm_router_pkg::CNT_SEL_W-1:0] counter_cfg_sel,
  input  wire logic [alarm_router_pkg::REG_W-1:0]     counter_cfg_wdata,
  output logic      [alarm_router_pkg::REG_W-1:0]     counter_cfg_rdata,
  output logic      [alarm_router_pkg::ZC_W-1:0]      integrity_zero_count,
  // Event counters timer
  input  wire logic                                   counter_timer_load,
  input  wire logic [alarm_router_pkg::TIMER_W-1:0]   counter_timer_initial_value,
  output logic                                        counter_timer_running,
  // Status and responses
  output logic      [alarm_router_pkg::REG_W-1:0]     event_syndrome_low,
  output logic      [alarm_router_pkg::REG_W-1:0]     event_syndrome_high,
  output logic      [alarm_router_pkg::NUM_ACTIONS-1:0] response_action,
  output logic                                        watchdog_irq
);

  import alarm_router_pkg::*;

  logic                   cold;
  logic [NUM_EVENTS-1:0]  sync_pulse;
  logic [NUM_EVENTS-1:0]  evt_pulse;
  logic [NUM_EVENTS-1:0]  eff_pulse;
  logic [NUM_EVENTS-1:0]  absorb_mask;
  logic [NUM_EVENTS-1:0]  clr_mask;
  logic [NUM_EVENTS-1:0]  set_mask;
  logic                   wdog_irq_int;

  assign cold = ~always_on_cold_reset_n;

  // ============================================================
  // Input synchronisers and edge detectors
  event_sync_edge #(
    .WIDTH (NUM_EVENTS)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (event_in),
    .pulse    (sync_pulse)
  );

  logic wdog_irq_d_ff, nxt_wdog_irq_d;

  // Internal source, same clock, so only edge-detected
  always_comb begin
    nxt_wdog_irq_d = wdog_irq_int;
    evt_pulse      = sync_pulse;
    evt_pulse[WDOG_EVENT] = wdog_irq_int & ~wdog_irq_d_ff;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdog_irq_d_ff <= 1'b0;
    end else begin
      wdog_irq_d_ff <= nxt_wdog_irq_d;
    end
  end

  // ============================================================
  // Event counters and pacing timer
  logic [REG_W-1:0]     cnt_cfg_ff [NUM_COUNTERS];
  logic [REG_W-1:0]     nxt_cnt_cfg [NUM_COUNTERS];
  logic [CNT_VAL_W-1:0] occ_ff [NUM_COUNTERS];
  logic [CNT_VAL_W-1:0] nxt_occ [NUM_COUNTERS];
  logic [TIMER_W-1:0]   timer_ff, nxt_timer;
  logic                 run_ff, nxt_run;
  logic                 timer_done;
  logic [REG_W-1:0]     cfg_rdata_ff, nxt_cfg_rdata;
  logic [ZC_W-1:0]      zc_ff, nxt_zc;

  always_comb begin
    nxt_timer  = timer_ff;
    nxt_run    = run_ff;
    timer_done = 1'b0;
    if (counter_timer_load) begin
      nxt_timer = counter_timer_initial_value;
      nxt_run   = (counter_timer_initial_value != TIMER_ZERO);
    end else if (run_ff) begin
      nxt_timer = timer_ff - TIMER_ONE;
      if (timer_ff == TIMER_ONE) begin
        nxt_run    = 1'b0;
        timer_done = 1'b1;
      end
    end
    if (cold) begin
      nxt_timer  = TIMER_ZERO;
      nxt_run    = 1'b0;
      timer_done = 1'b1;
    end
  end

  always_comb begin
    logic [EVT_W-1:0]     evt;
    logic [CNT_VAL_W-1:0] limit;
    evt         = '0;
    limit       = '0;
    absorb_mask = '0;
    nxt_zc      = '0;
    for (int c = 0; c < NUM_COUNTERS; c++) begin
      nxt_cnt_cfg[c] = cnt_cfg_ff[c];
      nxt_occ[c]     = occ_ff[c];
      evt   = cnt_cfg_ff[c][CNT_EVT_LSB +: EVT_W];
      limit = cnt_cfg_ff[c][CNT_VAL_LSB +: CNT_VAL_W];
      if (run_ff && cnt_cfg_ff[c][CNT_EN_BIT] && evt_pulse[evt] && (occ_ff[c] < limit)) begin
        absorb_mask[evt] = 1'b1;
        nxt_occ[c]       = occ_ff[c] + 1'b1;
      end
      if (timer_done) begin
        nxt_occ[c] = '0;
      end
      if (counter_cfg_wr && (int'(counter_cfg_sel) == c)) begin
        nxt_cnt_cfg[c] = counter_cfg_wdata;
      end
      for (int b = 0; b < REG_W; b++) begin
        nxt_zc = nxt_zc + {{(ZC_W-1){1'b0}}, ~cnt_cfg_ff[c][b]};
      end
    end
    // Unimplemented slots never stored, so they read as zero
    nxt_cfg_rdata = REG_ZERO;
    for (int c = 0; c < NUM_COUNTERS; c++) begin
      if (int'(counter_cfg_sel) == c) begin
        nxt_cfg_rdata = cnt_cfg_ff[c];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_ff     <= TIMER_ZERO;
      run_ff       <= 1'b0;
      cfg_rdata_ff <= REG_ZERO;
      zc_ff        <= '0;
      for (int c = 0; c < NUM_COUNTERS; c++) begin
        cnt_cfg_ff[c] <= REG_ZERO;
        occ_ff[c]     <= '0;
      end
    end else begin
      timer_ff     <= nxt_timer;
      run_ff       <= nxt_run;
      cfg_rdata_ff <= nxt_cfg_rdata;
      zc_ff        <= nxt_zc;
      for (int c = 0; c < NUM_COUNTERS; c++) begin
        cnt_cfg_ff[c] <= nxt_cnt_cfg[c];
        occ_ff[c]     <= nxt_occ[c];
      end
    end
  end

  // ============================================================
  // Internal status and syndrome
  logic [NUM_EVENTS-1:0] stat_ff, nxt_stat;
  logic [NUM_EVENTS-1:0] syn_ff, nxt_syn;
  logic [NUM_EVENTS-1:0] pend_ff, nxt_pend;

  always_comb begin
    eff_pulse = evt_pulse & ~absorb_mask;
    clr_mask  = event_clear_wr ? {event_clear_high, event_clear_low} : '0;
    // Colliding event is parked one cycle so software never misses it
    nxt_pend  = eff_pulse & clr_mask;
    set_mask  = (eff_pulse & ~clr_mask) | pend_ff;
    nxt_syn   = (syn_ff & ~clr_mask) | set_mask;
    nxt_stat  = (stat_ff & ~clr_mask) | set_mask;
    if (cold) begin
      nxt_stat = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_ff <= '0;
      syn_ff  <= '0;
      pend_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
      syn_ff  <= nxt_syn;
      pend_ff <= nxt_pend;
    end
  end

  // ============================================================
  // Response routing
  logic [ACT_W-1:0]       route_ff [NUM_EVENTS];
  logic [ACT_W-1:0]       nxt_route [NUM_EVENTS];
  logic [NUM_ACTIONS-1:0] act_ff, nxt_act;

  always_comb begin
    nxt_act = '0;
    for (int e = 0; e < NUM_EVENTS; e++) begin
      nxt_route[e] = route_ff[e];
      if (route_wr && (int'(route_sel) == (e / ROUTE_REGS))) begin
        nxt_route[e] = route_wdata[(e % ROUTE_REGS) * FIELD_STRIDE +: ACT_W];
      end
      if (stat_ff[e]) begin
        nxt_act[route_ff[e]] = 1'b1;
      end
    end
    if (cold) begin
      nxt_act = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_ff <= '0;
      for (int e = 0; e < NUM_EVENTS; e++) begin
        route_ff[e] <= '0;
      end
    end else begin
      act_ff <= nxt_act;
      for (int e = 0; e < NUM_EVENTS; e++) begin
        route_ff[e] <= nxt_route[e];
      end
    end
  end

  // ============================================================
  // Integrated watchdog
  logic [REG_W-1:0] wdog_iv_ff, nxt_wdog_iv;

  always_comb begin
    nxt_wdog_iv = wdog_iv_ff;
    if (wdog_iv_wr) begin
      nxt_wdog_iv = wdog_iv_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdog_iv_ff <= {2'b00, WDOG_MASK_RST, WDOG_INIT_RESET};
    end else begin
      wdog_iv_ff <= nxt_wdog_iv;
    end
  end

  alarm_watchdog #(
    .CNT_W (WDOG_CNT_W)
  ) u_wdog (
    .clk        (clk),
    .rst        (rst),
    .cold_clr   (cold),
    .action     (act_ff),
    .mask       (wdog_iv_ff[WDOG_MASK_LSB +: WDOG_MASK_W]),
    .init_value (wdog_iv_ff[WDOG_CNT_W-1:0]),
    .irq        (wdog_irq_int)
  );

  // ============================================================
  // Outputs
  assign event_syndrome_low     = syn_ff[REG_W-1:0];
  assign event_syndrome_high    = syn_ff[NUM_EVENTS-1:REG_W];
  assign response_action        = act_ff;
  assign watchdog_irq           = wdog_irq_int;
  assign watchdog_initial_value = wdog_iv_ff;
  assign counter_cfg_rdata      = cfg_rdata_ff;
  assign integrity_zero_count   = zc_ff;
  assign counter_timer_running  = run_ff;

endmodule : security_event_alarm_router

// file: verif/sensor_bank.sv
`timescale 1ns/1ps
module sensor_bank (
  // Clock
  input  wire logic        clk,
  // Bench requests and sensor lines
  input  wire logic [63:0] fire,
  output logic      [63:0] event_in
);
  // ==========================================
  // Pulse stretcher
  logic [63:0] hold_ff = 64'h0000_0000_0000_0000;
  always_ff @(posedge clk) begin
    hold_ff <= fire;
  end
  // Bit 1 is the internal watchdog event, so the sensor side leaves it low
  assign event_in = (fire | hold_ff) & 64'hFFFF_FFFF_FFFF_FFFD;
endmodule : sensor_bank

// file: verif/alarm_router_monitor.sv
`timescale 1ns/1ps
module alarm_router_monitor
  import alarm_router_pkg::*;
#(
  parameter int NUM_COUNTERS = 4
) (
  // Clock and resets
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        always_on_cold_reset_n,
  // Stimulus
  input wire logic [63:0] event_in,
  input wire logic        event_clear_wr,
  input wire logic [31:0] event_clear_low,
  input wire logic [31:0] event_clear_high,
  input wire logic [2:0]  counter_cfg_sel,
  // Observed outputs
  input wire logic [31:0] watchdog_initial_value,
  input wire logic [31:0] counter_cfg_rdata,
  input wire logic [31:0] event_syndrome_low,
  input wire logic [31:0] event_syndrome_high,
  input wire logic [7:0]  response_action,
  input wire logic        watchdog_irq
);
  // ==========================================
  // Helpers
  logic [63:0] syn;
  logic        trig;
  logic [31:0] run_ff;
  logic [31:0] nxt_run;
  assign syn  = {event_syndrome_high, event_syndrome_low};
  assign trig = |(response_action[7:2] & watchdog_initial_value[29:24]);
  // Consecutive cycles of masked trigger, for exact expiry timing
  always_comb begin
    nxt_run = trig ? run_ff + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_ff <= 32'h0000_0000;
    end else begin
      run_ff <= nxt_run;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Properties
  property p_keep;
    !event_clear_wr |=> (syn & $past(syn)) == $past(syn);
  endproperty
  a_keep: assert property (p_keep)
    else $error("syndrome bit dropped without clear");
  property p_clr;
    event_clear_wr |=> (syn & $past({event_clear_high, event_clear_low})) == 64'h0;
  endproperty
  a_clr: assert property (p_clr)
    else $error("cleared syndrome bit still set");
  property p_rise;
    $rose(event_syndrome_low[16]) |-> ($past(event_in[16], 5) || $past(event_in[16], 6));
  endproperty
  a_rise: assert property (p_rise)
    else $error("syndrome rose without synchronised event");
  property p_cold;
    !always_on_cold_reset_n [*3] |-> (response_action == 8'h00) && !watchdog_irq;
  endproperty
  a_cold: assert property (p_cold)
    else $error("actions survive cold reset");
  property p_route0;
    (syn == 64'h0) |=> (response_action == 8'h00);
  endproperty
  a_route0: assert property (p_route0)
    else $error("action without latched event");
  property p_stop;
    !trig |=> !watchdog_irq;
  endproperty
  a_stop: assert property (p_stop)
    else $error("watchdog irq without trigger");
  property p_hold;
    watchdog_irq && trig && always_on_cold_reset_n |=> watchdog_irq;
  endproperty
  a_hold: assert property (p_hold)
    else $error("watchdog irq dropped early");
  property p_expire;
    $rose(watchdog_irq) |-> run_ff == {8'h00, watchdog_initial_value[23:0]} + 32'h0000_0002;
  endproperty
  a_expire: assert property (p_expire)
    else $error("watchdog expiry at wrong cycle");
  property p_evt1;
    $rose(watchdog_irq) |-> ##[1:3] event_syndrome_low[1];
  endproperty
  a_evt1: assert property (p_evt1)
    else $error("watchdog event not latched");
  property p_raz;
    (32'(counter_cfg_sel) >= NUM_COUNTERS) |=> counter_cfg_rdata == 32'h0000_0000;
  endproperty
  a_raz: assert property (p_raz)
    else $error("unimplemented counter config not zero");
endmodule : alarm_router_monitor

bind security_event_alarm_router alarm_router_monitor #(.NUM_COUNTERS(NUM_COUNTERS)) u_mon (
  .clk(clk), .rst(rst), .always_on_cold_reset_n(always_on_cold_reset_n), .event_in(event_in),
  .event_clear_wr(event_clear_wr), .event_clear_low(event_clear_low),
  .event_clear_high(event_clear_high), .counter_cfg_sel(counter_cfg_sel),
  .watchdog_initial_value(watchdog_initial_value), .counter_cfg_rdata(counter_cfg_rdata),
  .event_syndrome_low(event_syndrome_low), .event_syndrome_high(event_syndrome_high),
  .response_action(response_action), .watchdog_irq(watchdog_irq));

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import alarm_router_pkg::*;
  // ==========================================
  // Signals
  logic clk = 1'b0;
  logic rst, always_on_cold_reset_n, event_clear_wr, route_wr, wdog_iv_wr;
  logic counter_cfg_wr, counter_timer_load, counter_timer_running, watchdog_irq;
  logic [63:0] fire, event_in;
  logic [31:0] event_clear_low, event_clear_high, route_wdata, wdog_iv_wdata;
  logic [31:0] counter_cfg_wdata, counter_timer_initial_value, watchdog_initial_value;
  logic [31:0] counter_cfg_rdata, event_syndrome_low, event_syndrome_high;
  logic [2:0]  route_sel, counter_cfg_sel;
  logic [9:0]  integrity_zero_count;
  logic [7:0]  response_action;
  int          miscompares, cmp_count, i;
  always #2 clk = ~clk;
  // Short watchdog count keeps expiry inside a few cycles
  security_event_alarm_router #(.NUM_COUNTERS(4), .WDOG_INIT_RESET(24'h00_0008)) DUT (
    .clk(clk), .rst(rst), .always_on_cold_reset_n(always_on_cold_reset_n),
    .event_in(event_in), .event_clear_wr(event_clear_wr), .event_clear_low(event_clear_low),
    .event_clear_high(event_clear_high), .route_wr(route_wr), .route_sel(route_sel),
    .route_wdata(route_wdata), .wdog_iv_wr(wdog_iv_wr), .wdog_iv_wdata(wdog_iv_wdata),
    .watchdog_initial_value(watchdog_initial_value), .counter_cfg_wr(counter_cfg_wr),
    .counter_cfg_sel(counter_cfg_sel), .counter_cfg_wdata(counter_cfg_wdata),
    .counter_cfg_rdata(counter_cfg_rdata), .integrity_zero_count(integrity_zero_count),
    .counter_timer_load(counter_timer_load),
    .counter_timer_initial_value(counter_timer_initial_value),
    .counter_timer_running(counter_timer_running), .event_syndrome_low(event_syndrome_low),
    .event_syndrome_high(event_syndrome_high), .response_action(response_action),
    .watchdog_irq(watchdog_irq));
  sensor_bank u_sensors (.clk(clk), .fire(fire), .event_in(event_in));
  // ==========================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic pulse_evt(input logic [63:0] m);
    fire = m;
    tick(1);
    fire = 64'h0;
    tick(12);
  endtask : pulse_evt
  task automatic clear_all();
    event_clear_wr = 1'b1;
    tick(1);
    event_clear_wr = 1'b0;
    tick(3);
  endtask : clear_all
  task automatic wait_irq();
    for (i = 0; i < 40 && watchdog_irq !== 1'b1; i++) tick(1);
    if (watchdog_irq !== 1'b1) begin
      miscompares++;
      final_report();
    end
  endtask : wait_irq
  task automatic wr_cfg(input logic [2:0] n, input logic [31:0] d);
    counter_cfg_wr = 1'b1;
    counter_cfg_sel = n;
    counter_cfg_wdata = d;
    tick(1);
    counter_cfg_wr = 1'b0;
    tick(1);
  endtask : wr_cfg
  task automatic load_timer(input logic [31:0] v);
    counter_timer_load = 1'b1;
    counter_timer_initial_value = v;
    tick(1);
    counter_timer_load = 1'b0;
    tick(1);
  endtask : load_timer
  // ==========================================
  // Scenarios
  task automatic t_route();
    check("wdog_iv", watchdog_initial_value, 32'h3F00_0008);
    check("zero_cnt", integrity_zero_count, 10'h080);
    check("syn", {event_syndrome_high, event_syndrome_low}, 64'h0);
    route_wr = 1'b1;
    route_sel = 3'h2;
    route_wdata = 32'h7654_3210;
    tick(1);
    route_wr = 1'b0;
    pulse_evt(64'h0000_0000_00FF_0000);
    check("syn_low", event_syndrome_low, 32'h00FF_0000);
    check("action", response_action, 8'hFF);
    wait_irq();
    tick(4);
    check("evt1", event_syndrome_low[1], 1'b1);
    clear_all();
    check("action", response_action, 8'h00);
    check("irq", watchdog_irq, 1'b0);
    $display("t_route done");
  endtask : t_route
  task automatic t_wdmask();
    wdog_iv_wr = 1'b1;
    wdog_iv_wdata = 32'h0100_0003;
    tick(1);
    wdog_iv_wr = 1'b0;
    check("wdog_iv", watchdog_initial_value, 32'h0100_0003);
    pulse_evt(64'h0000_0000_0008_0000);
    check("action3", response_action, 8'h08);
    tick(20);
    check("irq_masked", watchdog_irq, 1'b0);
    pulse_evt(64'h0000_0000_0004_0000);
    wait_irq();
    clear_all();
    $display("t_wdmask done");
  endtask : t_wdmask
  task automatic t_cold();
    pulse_evt(64'h0000_0000_0001_0000);
    check("action", response_action, 8'h01);
    always_on_cold_reset_n = 1'b0;
    tick(3);
    always_on_cold_reset_n = 1'b1;
    tick(1);
    check("action", response_action, 8'h00);
    check("syn_low", event_syndrome_low, 32'h0001_0000);
    clear_all();
    // Event lands on the same edge as its clear
    fire[16] = 1'b1;
    tick(1);
    fire = 64'h0;
    tick(3);
    event_clear_wr = 1'b1;
    tick(1);
    event_clear_wr = 1'b0;
    tick(4);
    check("collide", event_syndrome_low, 32'h0001_0000);
    clear_all();
    fire[16] = 1'b1;
    tick(12);
    clear_all();
    tick(10);
    check("level", event_syndrome_low, 32'h0);
    fire = 64'h0;
    tick(6);
    $display("t_cold done");
  endtask : t_cold
  task automatic t_counter();
    wr_cfg(3'h0, 32'h8000_0205);
    wr_cfg(3'h6, 32'hFFFF_FFFF);
    tick(2);
    check("cfg6", counter_cfg_rdata, 32'h0);
    check("zero_cnt", integrity_zero_count, 10'h07C);
    counter_cfg_sel = 3'h0;
    tick(2);
    check("cfg0", counter_cfg_rdata, 32'h8000_0205);
    pulse_evt(64'h20);
    check("direct", event_syndrome_low, 32'h20);
    clear_all();
    load_timer(32'h0000_0400);
    check("running", counter_timer_running, 1'b1);
    pulse_evt(64'h20);
    pulse_evt(64'h20);
    check("absorb", event_syndrome_low, 32'h0);
    pulse_evt(64'h20);
    check("pass", event_syndrome_low, 32'h20);
    clear_all();
    load_timer(32'h0000_0010);
    for (i = 0; i < 40 && counter_timer_running !== 1'b0; i++) tick(1);
    check("expired", counter_timer_running, 1'b0);
    load_timer(32'h0000_0400);
    pulse_evt(64'h20);
    check("recount", event_syndrome_low, 32'h0);
    $display("t_counter done");
  endtask : t_counter
  task automatic t_por();
    pulse_evt(64'h0000_0001_0000_0000);
    check("syn_high", event_syndrome_high, 32'h1);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(2);
    check("syn_high", event_syndrome_high, 32'h0);
    check("wdog_iv", watchdog_initial_value, 32'h3F00_0008);
    $display("t_por done");
  endtask : t_por
  // ==========================================
  // Main sequence
  initial begin
    rst = 1'b1;
    always_on_cold_reset_n = 1'b1;
    {event_clear_wr, route_wr, wdog_iv_wr, counter_cfg_wr, counter_timer_load} = 5'h00;
    {route_wdata, wdog_iv_wdata, counter_cfg_wdata} = 96'h0;
    {route_sel, counter_cfg_sel, fire} = 70'h0;
    counter_timer_initial_value = 32'h0;
    event_clear_low = 32'hFFFF_FFFF;
    event_clear_high = 32'hFFFF_FFFF;
    tick(10);
    rst = 1'b0;
    tick(2);
    t_route();
    t_wdmask();
    t_cold();
    t_counter();
    t_por();
    final_report();
  end
endmodule : tb_top
